// >>> src/ssm_defines.svh
// register offsets, field positions, reset values and fixed counts of the
// clock-synchronous serial channel; assumes a 32-bit APB with byte addresses
`ifndef SSM_DEFINES_SVH
`define SSM_DEFINES_SVH

// register byte offsets
`define SSM_OFF_MODE 8'h00
`define SSM_OFF_DIV 8'h04
`define SSM_OFF_ENABLE 8'h08
`define SSM_OFF_TXBUF 8'h0C
`define SSM_OFF_RXBUF 8'h10
`define SSM_OFF_STATUS 8'h14
`define SSM_OFF_IRQ_STAT 8'h18
`define SSM_OFF_IRQ_MASK 8'h1C

// mode register fields
`define SSM_M_PRESC 0
`define SSM_M_HS_RTS 2
`define SSM_M_CLK_EXT 3
`define SSM_M_HS_DIS 4
`define SSM_M_CKPOL 6
`define SSM_M_MSB 7
`define SSM_M_OPEN_DRAIN 8
`define SSM_M_POL_REV 9
`define SSM_M_DATA_INV 10
`define SSM_M_CLKSEL 11
`define SSM_M_CONT_RX 13
`define SSM_M_TX_CAUSE 14

// enable register fields
`define SSM_E_TX 0
`define SSM_E_RX 2

// interrupt status and mask fields
`define SSM_I_TX 0
`define SSM_I_RX 1
`define SSM_I_OVR 2

// reset values
`define SSM_MODE_RST 16'h0000
`define SSM_DIV_RST 8'h00
`define SSM_MASK_RST 3'h0

// fixed counts and the alternate clock select code
`define SSM_FRAME_BITS 8
`define SSM_PRE_F8 8
`define SSM_PRE_F32 32
`define SSM_CLKSEL_ALT 2'h2

`endif

// >>> src/ssm_pkg.sv
// types shared by the synchronous serial channel modules
// assumes ssm_defines.svh supplies the numeric constants
package ssm_pkg;
  typedef enum logic [1:0] {SSM_IDLE, SSM_SHIFT, SSM_DONE} ssm_state_t;
  typedef enum logic [1:0] {SSM_F1, SSM_F8, SSM_F32, SSM_FRES} ssm_presc_t;
  typedef logic [7:0] ssm_byte_t;
endpackage

// >>> src/ssm_rate_gen.sv
// transfer rate generator: prescaler (f1/f8/f32) then 8-bit divisor n
// assumes run stays low while the clock is idle or external
`timescale 1ns/1ps
`include "ssm_defines.svh"
module ssm_rate_gen (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic run, // count while high
  input wire ssm_pkg::ssm_presc_t presc, // prescaler select
  input wire logic [7:0] div, // divisor n, 0..255
  output logic tick // one-cycle half-period pulse
);
  import ssm_pkg::*;

  logic [4:0] pre_cnt;
  logic [7:0] div_cnt;
  logic pre_tick;

  // prescaled enable; f1 passes every cycle
  always_comb begin
    case (presc)
      SSM_F8: pre_tick = (pre_cnt[2:0] == 3'(`SSM_PRE_F8 - 1));
      SSM_F32: pre_tick = (pre_cnt == 5'(`SSM_PRE_F32 - 1));
      default: pre_tick = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 5'h0;
    end else if (!run) begin
      pre_cnt <= 5'h0;
    end else begin
      pre_cnt <= pre_cnt + 5'h1;
    end
  end

  // n+1 prescaled pulses per half period; any n from 0 to 255 accepted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end else if (!run) begin
      div_cnt <= div;
      tick <= 1'b0;
    end else if (pre_tick && div_cnt == 8'h00) begin
      div_cnt <= div;
      tick <= 1'b1;
    end else begin
      if (pre_tick) begin
        div_cnt <= div_cnt - 8'h01;
      end
      tick <= 1'b0;
    end
  end

  // helper: cycles since last tick, for the spacing check
  logic [13:0] gap;
  logic [13:0] period;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 14'h0;
    end else if (!run) begin
      gap <= 14'h0;
    end else if (tick) begin
      gap <= 14'h1; // the cycle after a tick is the first of the next gap
    end else begin
      gap <= gap + 14'h1;
    end
  end
  assign period = (14'(div) + 14'h1) * ((presc == SSM_F8) ? 14'(`SSM_PRE_F8) :
                  (presc == SSM_F32) ? 14'(`SSM_PRE_F32) : 14'h1);

  AST_TICK_GAP: assert property (@(posedge pclk) disable iff (!presetn)
    run && $past(run) && $stable(div) && $stable(presc) && $rose(tick) |->
      gap == period)
    else $error("half-period spacing differs from (n+1) prescaled cycles");
endmodule

// >>> src/ssm_shifter.sv
// 8-bit shift register used for both directions at once
// assumes launch and sample never come in the same cycle
`timescale 1ns/1ps
module ssm_shifter (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic load, // take load_data
  input wire ssm_pkg::ssm_byte_t load_data, // word to send
  input wire logic launch, // present next bit
  input wire logic sample, // shift in one bit
  input wire logic msb_first, // bit order select
  input wire logic sin, // received bit
  output ssm_pkg::ssm_byte_t data, // shift contents
  output logic bit_out // bit being sent
);
  import ssm_pkg::*;

  // one register serves tx and rx: each sample frees the bit just sent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data <= 8'h00;
      bit_out <= 1'b1;
    end else if (load) begin
      data <= load_data;
    end else if (launch) begin
      bit_out <= msb_first ? data[7] : data[0];
    end else if (sample) begin
      data <= msb_first ? {data[6:0], sin} : {sin, data[7:1]};
    end
  end

  AST_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
    launch && !load |=> bit_out == ($past(msb_first) ? $past(data[7]) : $past(data[0])))
    else $error("launched bit does not follow the selected bit order");
endmodule

// >>> src/ssm_sync_serial.sv
// clock-synchronous serial channel: APB registers, frame control, pins, irq
// assumes pin inputs already synchronous to pclk; one frame is 8 bits
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ssm_defines.svh"
module ssm_sync_serial #(
  parameter int ADDR_W = 8,
  parameter bit HAS_ALT_CLK = 1'b1,
  parameter bit HAS_DATA_INV = 1'b1
) (
  input wire logic pclk, // system clock, 25 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  output logic serial_out_pin, // serial data out level
  output logic serial_out_pin_oe_n, // serial out enable, low drives
  input wire logic serial_in_pin, // serial data in
  input wire logic transfer_clock_pin_in, // clock pin level
  output logic transfer_clock_pin_out, // clock pin drive level
  output logic transfer_clock_pin_oe_n, // clock pin enable, low drives
  output logic alt_clock_pin_select_out, // second clock pin level
  output logic alt_clock_pin_select_oe_n, // second clock pin enable
  input wire logic handshake_in, // clear-to-send, low means go
  output logic handshake_out, // request-to-send, low means ready
  output logic handshake_oe_n, // handshake enable, low drives
  output logic irq // level interrupt
);
  import ssm_pkg::*;

  logic [15:0] mode;
  logic [7:0] div;
  logic tx_en;
  logic rx_en;
  ssm_byte_t txbuf;
  logic tx_full;
  ssm_byte_t rxbuf;
  logic rx_full;
  logic overrun;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  ssm_state_t state;
  logic [3:0] bit_cnt;
  logic clk_lvl;
  logic ext_q;
  logic rx_arm;

  // mode decode
  logic clk_ext, idle_lvl, msb_first, open_drain, pol_rev, data_inv;
  logic hs_dis, hs_rts, cts_mode, cont_rx, tx_cause, use_alt;
  ssm_presc_t presc;
  assign clk_ext = mode[`SSM_M_CLK_EXT];
  assign idle_lvl = ~mode[`SSM_M_CKPOL];
  assign msb_first = mode[`SSM_M_MSB];
  assign open_drain = mode[`SSM_M_OPEN_DRAIN];
  assign pol_rev = HAS_DATA_INV & mode[`SSM_M_POL_REV];
  assign data_inv = HAS_DATA_INV & mode[`SSM_M_DATA_INV];
  assign hs_dis = mode[`SSM_M_HS_DIS];
  assign hs_rts = mode[`SSM_M_HS_RTS];
  assign cts_mode = ~hs_dis & ~hs_rts;
  assign cont_rx = mode[`SSM_M_CONT_RX];
  assign tx_cause = mode[`SSM_M_TX_CAUSE];
  assign presc = ssm_presc_t'(mode[`SSM_M_PRESC +: 2]);
  // alternate pin only with the internal clock
  assign use_alt = HAS_ALT_CLK & ~clk_ext &
                   (mode[`SSM_M_CLKSEL +: 2] == `SSM_CLKSEL_ALT);

  // apb access decode
  logic acc, wr_acc, rd_acc, mapped;
  logic [ADDR_W-1:0] a8;
  assign a8 = paddr;
  assign acc = psel & penable & pready;
  assign wr_acc = acc & pwrite & ~pslverr;
  assign rd_acc = acc & ~pwrite & ~pslverr;
  always_comb begin
    case (8'(a8))
      `SSM_OFF_MODE, `SSM_OFF_DIV, `SSM_OFF_ENABLE, `SSM_OFF_TXBUF,
      `SSM_OFF_RXBUF, `SSM_OFF_STATUS, `SSM_OFF_IRQ_STAT,
      `SSM_OFF_IRQ_MASK: mapped = (a8[1:0] == 2'h0);
      default: mapped = 1'b0;
    endcase
  end
  logic wr_txbuf, rd_rxbuf;
  assign wr_txbuf = wr_acc && 8'(a8) == `SSM_OFF_TXBUF;
  assign rd_rxbuf = rd_acc && 8'(a8) == `SSM_OFF_RXBUF;

  // frame events
  logic tick, ext_lead, ext_trail, lead_ev, trail_ev, start, last;
  logic sin;
  ssm_byte_t sh_data;
  logic sh_bit;
  assign ext_lead = (ext_q == idle_lvl) & (transfer_clock_pin_in != idle_lvl);
  assign ext_trail = (ext_q != idle_lvl) & (transfer_clock_pin_in == idle_lvl);
  // external clock: one bit per edge pair of the peer's clock
  assign lead_ev = (state == SSM_SHIFT) &
                   (clk_ext ? ext_lead : tick & (clk_lvl == idle_lvl));
  assign trail_ev = (state == SSM_SHIFT) &
                    (clk_ext ? ext_trail : tick & (clk_lvl != idle_lvl));
  assign last = trail_ev & (bit_cnt == 4'(`SSM_FRAME_BITS - 1));
  // a word must be loaded; an external clock must rest at idle
  assign start = (state == SSM_IDLE) & tx_en & tx_full &
                 (~cts_mode | ~handshake_in) &
                 (~clk_ext | (transfer_clock_pin_in == idle_lvl));
  assign sin = serial_in_pin ^ pol_rev;

  ssm_rate_gen u_rate (
    .pclk(pclk),
    .presetn(presetn),
    .run((state == SSM_SHIFT) & ~clk_ext),
    .presc(presc),
    .div(div),
    .tick(tick)
  );

  ssm_shifter u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .load(start),
    .load_data(txbuf),
    .launch(lead_ev),
    .sample(trail_ev),
    .msb_first(msb_first),
    .sin(sin),
    .data(sh_data),
    .bit_out(sh_bit)
  );

  // frame sequencer; tx runs even when only receiving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SSM_IDLE;
      bit_cnt <= 4'h0;
      rx_arm <= 1'b0;
    end else begin
      case (state)
        SSM_IDLE: begin
          if (start) begin
            state <= SSM_SHIFT;
            bit_cnt <= 4'h0;
            rx_arm <= rx_en & tx_en;
          end
        end
        SSM_SHIFT: begin
          if (last) begin
            state <= SSM_DONE;
          end
          if (trail_ev) begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        default: begin
          state <= SSM_IDLE;
        end
      endcase
    end
  end

  // internal transfer clock level; rests at the idle level between frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_lvl <= 1'b1;
      ext_q <= 1'b1;
    end else begin
      ext_q <= transfer_clock_pin_in;
      if (state != SSM_SHIFT) begin
        clk_lvl <= idle_lvl;
      end else if (tick) begin
        clk_lvl <= ~clk_lvl;
      end
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `SSM_MODE_RST;
      div <= `SSM_DIV_RST;
      tx_en <= 1'b0;
      rx_en <= 1'b0;
      irq_mask <= `SSM_MASK_RST;
    end else if (wr_acc) begin
      case (8'(a8))
        `SSM_OFF_MODE: mode <= pwdata[15:0];
        `SSM_OFF_DIV: div <= pwdata[7:0];
        `SSM_OFF_ENABLE: begin
          tx_en <= pwdata[`SSM_E_TX];
          rx_en <= pwdata[`SSM_E_RX];
        end
        `SSM_OFF_IRQ_MASK: irq_mask <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // transmit buffer; a buffer write wins over the start that empties it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txbuf <= 8'h00;
      tx_full <= 1'b0;
    end else if (wr_txbuf) begin
      txbuf <= data_inv ? ~pwdata[7:0] : pwdata[7:0];
      tx_full <= 1'b1;
    end else if (cont_rx && rx_en && rd_rxbuf) begin
      tx_full <= 1'b1; // old word re-sent as dummy
    end else if (start) begin
      tx_full <= 1'b0;
    end
  end

  // receive buffer; receive only stores words when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxbuf <= 8'h00;
      rx_full <= 1'b0;
      overrun <= 1'b0;
    end else if (state == SSM_DONE && rx_arm) begin
      rxbuf <= sh_data; // overwrite even on overrun
      rx_full <= 1'b1;
      overrun <= overrun | rx_full;
    end else if (rd_rxbuf) begin
      rx_full <= 1'b0;
      overrun <= 1'b0;
    end
  end

  // sticky events, write one to clear, a new event wins over the clear
  logic [2:0] ev, clr;
  assign ev[`SSM_I_TX] = tx_cause ? (state == SSM_DONE) : start;
  assign ev[`SSM_I_RX] = (state == SSM_DONE) & rx_arm & ~rx_full;
  assign ev[`SSM_I_OVR] = (state == SSM_DONE) & rx_arm & rx_full;
  assign clr = (wr_acc && 8'(a8) == `SSM_OFF_IRQ_STAT) ? pwdata[2:0] : 3'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~clr) | ev;
      irq <= |(irq_stat & irq_mask);
    end
  end

  // apb slave: read data captured in setup, zero-wait access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable) begin
        case (8'(a8))
          `SSM_OFF_MODE: prdata <= {16'h0000, mode};
          `SSM_OFF_DIV: prdata <= {24'h00_0000, div};
          `SSM_OFF_ENABLE: prdata <= {29'h0, rx_en, 1'b0, tx_en};
          `SSM_OFF_TXBUF: prdata <= {24'h00_0000, txbuf};
          `SSM_OFF_RXBUF: prdata <= {24'h00_0000, data_inv ? ~rxbuf : rxbuf};
          // input pin level visible here for use as a plain port
          `SSM_OFF_STATUS: prdata <= {27'h0, serial_in_pin, overrun, rx_full, tx_full,
                                      state != SSM_IDLE};
          `SSM_OFF_IRQ_STAT: prdata <= {29'h0, irq_stat};
          `SSM_OFF_IRQ_MASK: prdata <= {29'h0, irq_mask};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // pin drivers, all registered so the clock and data keep the same lag
  logic data_lvl;
  assign data_lvl = (state == SSM_IDLE) ? 1'b1 : (sh_bit ^ pol_rev);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_pin <= 1'b1;
      serial_out_pin_oe_n <= 1'b0;
      transfer_clock_pin_out <= 1'b1;
      transfer_clock_pin_oe_n <= 1'b1;
      alt_clock_pin_select_out <= 1'b1;
      alt_clock_pin_select_oe_n <= 1'b1;
      handshake_out <= 1'b1;
      handshake_oe_n <= 1'b1;
    end else begin
      // open-drain only pulls low; high means released
      serial_out_pin <= open_drain ? 1'b0 : data_lvl;
      serial_out_pin_oe_n <= open_drain & data_lvl;
      transfer_clock_pin_out <= clk_lvl;
      transfer_clock_pin_oe_n <= clk_ext | use_alt;
      alt_clock_pin_select_out <= clk_lvl;
      alt_clock_pin_select_oe_n <= ~use_alt;
      handshake_out <= ~(rx_en & tx_en & tx_full & ~rx_full);
      handshake_oe_n <= hs_dis | ~hs_rts;
    end
  end

  sequence seq_last_bit;
    state == SSM_SHIFT && trail_ev && bit_cnt == 4'h7;
  endsequence
  sequence seq_done_then_idle;
    state == SSM_DONE ##1 state == SSM_IDLE;
  endsequence

  AST_FRAME_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    seq_last_bit |=> seq_done_then_idle)
    else $error("frame did not end after the eighth bit");
  AST_RX_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
    seq_last_bit ##1 (rx_arm && !rx_full) |=> irq_stat[`SSM_I_RX])
    else $error("receive event missing after eighth bit");
  AST_START_COND: assert property (@(posedge pclk) disable iff (!presetn)
    state == SSM_IDLE ##1 state == SSM_SHIFT && rx_arm |->
      $past(tx_full) && $past(rx_en) && $past(tx_en) &&
      (!$past(clk_ext) || $past(transfer_clock_pin_in) == $past(idle_lvl)))
    else $error("reception started without its start conditions");
  AST_OVR_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    state == SSM_DONE && rx_arm && rx_full && clr == 3'h0 |=>
      irq_stat[`SSM_I_RX] == $past(irq_stat[`SSM_I_RX]) && rxbuf == $past(sh_data))
    else $error("overrun changed the receive flag or kept the old word");
  AST_CLK_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    state == SSM_IDLE && $past(state == SSM_IDLE) && $stable(mode) |-> clk_lvl == idle_lvl)
    else $error("transfer clock not at idle level between frames");
  AST_ALT_EXT: assert property (@(posedge pclk) disable iff (!presetn)
    $past(clk_ext) |-> alt_clock_pin_select_oe_n && transfer_clock_pin_oe_n)
    else $error("clock driven while external clock selected");
  AST_CLK_DIR: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) && !$past(clk_ext) && !$past(use_alt) |-> !transfer_clock_pin_oe_n)
    else $error("clock pin not driven with internal clock");
  AST_IDLE_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    $past(state == SSM_IDLE) |->
      ($past(open_drain) ? serial_out_pin_oe_n : serial_out_pin && !serial_out_pin_oe_n))
    else $error("serial output not high or floating before transfer");
  AST_CONT_REARM: assert property (@(posedge pclk) disable iff (!presetn)
    cont_rx && rx_en && rd_rxbuf && state == SSM_IDLE |=> tx_full)
    else $error("buffer read did not re-arm continuous receive");
  AST_HS_PORT: assert property (@(posedge pclk) disable iff (!presetn)
    $past(hs_dis) |-> handshake_oe_n)
    else $error("handshake pin driven while disabled");
endmodule

// >>> src/ssm_sync_serial_pad.sv
// (intentionally empty) 
`timescale 1ns/1ps

// >>> testbench/ssm_peer.sv
// far-side peer of the synchronous serial channel: answers one word a frame
// assumes the channel drives the transfer clock; idle level high when pol is 0
`timescale 1ns/1ps
module ssm_peer (
  input wire logic pclk, // system clock
  input wire logic clk_pin, // transfer clock wire level
  input wire logic pol, // clock polarity setting
  input wire logic msb, // bit order setting
  input wire logic arm, // restart the bit count
  input wire logic [7:0] word, // word sent to the channel
  input wire logic sout, // serial data wire from the channel
  output logic sin, // serial data to the channel
  output logic [7:0] cap // word taken from the channel
);
  logic prev;
  int k;
  // edges seen one pclk late, as a real peer would; leading edge launches
  always @(posedge pclk) begin
    prev <= clk_pin;
    if (arm) begin
      k <= 0;
      cap <= 8'h00;
    end else if (clk_pin !== prev && k < 8) begin
      if (clk_pin === pol) begin
        sin <= word[msb ? 7 - k : k];
      end else begin
        cap <= msb ? {cap[6:0], sout} : {sout, cap[7:1]};
        k <= k + 1;
      end
    end else if (k == 8) begin
      sin <= ~sin; // released line carries no stale level
    end
  end
  initial begin
    prev = 1'b1;
    k = 8;
    sin = 1'b0;
    cap = 8'h00;
  end
endmodule

// >>> testbench/test_ssm_sync_serial.sv
// self-checking bench of the synchronous serial channel over apb
// assumes one pclk domain and a peer model on the serial pins
`timescale 1ns/1ps
`include "ssm_defines.svh"
module test_ssm_sync_serial;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, serr, sout, sout_oe_n, sin, clk_out, clk_oe_n;
  logic alt_out, alt_oe_n, hs_out, hs_oe_n, irq, last, arm = 1'b0, cts_n = 1'b0;
  logic [7:0] pword = 8'h00;
  logic [7:0] cap;
  logic [15:0] mode = 16'h0000;
  logic [15:0] pm [6] = '{16'h1000, 16'h1008, 16'h0000, 16'h0004, 16'h0014, 16'h0100};
  logic [3:0] pe [6] = '{4'h6, 4'hE, 4'hA, 4'h8, 4'hA, 4'hB};
  logic [15:0] fm [7] = '{16'h0000, 16'h0040, 16'h0080, 16'h00C0, 16'h0400, 16'h0600,
    16'h0200};
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int cnt = 0;
  int hp = 0;
  // wire levels: pull-up on released lines
  wire so_w = sout_oe_n ? 1'b1 : sout;
  wire clk_w = clk_oe_n ? (alt_oe_n ? 1'b1 : alt_out) : clk_out;
  always #20 pclk = ~pclk;
  ssm_sync_serial i_ssm_sync_serial (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_out_pin(sout), .serial_out_pin_oe_n(sout_oe_n),
    .serial_in_pin(sin), .transfer_clock_pin_in(clk_w), .transfer_clock_pin_out(clk_out),
    .transfer_clock_pin_oe_n(clk_oe_n), .alt_clock_pin_select_out(alt_out),
    .alt_clock_pin_select_oe_n(alt_oe_n), .handshake_in(cts_n), .handshake_out(hs_out),
    .handshake_oe_n(hs_oe_n), .irq(irq));
  ssm_peer i_ssm_peer (.pclk(pclk), .clk_pin(clk_w), .pol(mode[6]), .msb(mode[7]),
    .arm(arm), .word(pword), .sout(so_w), .sin(sin), .cap(cap));
  // half-period meter on the clock pin, plus the hang limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    last <= clk_out;
    cnt <= (clk_out !== last) ? 1 : cnt + 1;
    if (clk_out !== last) hp <= cnt;
    if (cyc == 40000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one apb transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // pready, prdata and pslverr taken at the rising edge that completes the access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // polls one status bit; a hang is caught by the cycle ceiling
  task automatic wait_st(input int b);
    do begin
      apb(1'b0, `SSM_OFF_STATUS, 16'h0000);
    end while (q[b] !== 1'b1);
  endtask
  task automatic arm_peer(input logic [7:0] p);
    pword <= p;
    arm <= 1'b1;
    @(posedge pclk);
    arm <= 1'b0;
  endtask
  // full frame both ways; inversion and pin reversal each flip the word
  task automatic frame(input logic [15:0] m, input logic [7:0] t, input logic [7:0] p);
    logic [7:0] x;
    x = {8{m[10] ^ m[9]}};
    mode <= m;
    apb(1'b1, `SSM_OFF_MODE, m);
    apb(1'b1, `SSM_OFF_ENABLE, 16'h0005);
    arm_peer(p);
    apb(1'b1, `SSM_OFF_TXBUF, {8'h00, t});
    wait_st(2);
    chk(hp, 4);
    chk(cap, t ^ x);
    apb(1'b0, `SSM_OFF_RXBUF, 16'h0000);
    chk(q, p ^ x);
  endtask
  task automatic end_sim();
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk({sout, sout_oe_n}, 2'b10);
    apb(1'b0, 8'h20, 16'h0000);
    chk(q, 32'h0000_0000);
    chk(serr, 1'b1);
    apb(1'b1, `SSM_OFF_DIV, 16'h00FF);
    apb(1'b0, `SSM_OFF_DIV, 16'h0000);
    chk(q, 32'h0000_00FF);
    apb(1'b1, `SSM_OFF_DIV, 16'h0003);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `SSM_OFF_MODE, pm[i]);
      apb(1'b0, `SSM_OFF_MODE, 16'h0000);
      chk({alt_oe_n, clk_oe_n, hs_oe_n, sout_oe_n}, pe[i]);
      // idle clock pins rest high; rts stays high while both enables are off
      chk({alt_out, hs_out, q[15:0]}, {2'b11, pm[i]});
    end
    for (int i = 0; i < 7; i++) begin
      frame(fm[i], 8'(8'h35 ^ (8'h11 * i)), 8'(8'hC6 + i));
    end
    // second word lands before the first is read; clear-to-send held off at first
    apb(1'b1, `SSM_OFF_MODE, 16'h0000);
    arm_peer(8'h4B);
    cts_n <= 1'b1;
    apb(1'b1, `SSM_OFF_TXBUF, 16'h00A1);
    apb(1'b0, `SSM_OFF_STATUS, 16'h0000);
    chk(q[1:0], 2'b10);
    cts_n <= 1'b0;
    wait_st(2);
    apb(1'b1, `SSM_OFF_IRQ_STAT, 16'h0007);
    arm_peer(8'h96);
    apb(1'b1, `SSM_OFF_TXBUF, 16'h005E);
    wait_st(3);
    apb(1'b0, `SSM_OFF_IRQ_STAT, 16'h0000);
    chk(q, 32'h0000_0005);
    apb(1'b0, `SSM_OFF_RXBUF, 16'h0000);
    chk(q, 32'h0000_0096);
    chk(irq, 1'b0);
    apb(1'b1, `SSM_OFF_IRQ_MASK, 16'h0004);
    apb(1'b0, `SSM_OFF_IRQ_MASK, 16'h0000);
    chk(q, 32'h0000_0004);
    chk(irq, 1'b1);
    apb(1'b1, `SSM_OFF_IRQ_STAT, 16'h0004);
    apb(1'b0, `SSM_OFF_IRQ_STAT, 16'h0000);
    chk(irq, 1'b0);
    chk(q, 32'h0000_0001);
    // continuous receive: the read alone starts the next frame
    arm_peer(8'h3A);
    apb(1'b1, `SSM_OFF_MODE, 16'h2000);
    apb(1'b1, `SSM_OFF_TXBUF, 16'h0011);
    wait_st(2);
    arm_peer(8'h77);
    apb(1'b0, `SSM_OFF_RXBUF, 16'h0000);
    chk(q, 32'h0000_003A);
    wait_st(2);
    chk(cap, 8'h11);
    apb(1'b1, `SSM_OFF_ENABLE, 16'h0000);
    apb(1'b0, `SSM_OFF_RXBUF, 16'h0000);
    chk(q, 32'h0000_0077);
    end_sim();
  end
endmodule
